// [hw/mst_translator.v]
`include "mst_regs.vh"

// Translator, decay selection and fixed off-time chopper for two bridges.
// Comparator, timing node and fault levels arrive as synchronous inputs.
module mst_translator #(
    parameter OC_LATCH_CYC = `MST_OC_LATCH_CYC,
    parameter OC_BLANK_CYC = `MST_OC_BLANK_CYC,
    parameter BLANK_CYC = 19,
    parameter OFF_CYC = 760
) (
    input wire clk_sys_in,
    input wire nrst_in,
    input wire advance_in,
    input wire direction_in,
    input wire resolution_sel_lo_in,
    input wire resolution_sel_hi_in,
    input wire [1:0] fast_decay_fraction_in,
    input wire translator_clear_n_in,
    input wire outputs_on_n_in,
    input wire low_power_n_in,
    input wire rectifier_disable_in,
    input wire [1:0] trip_in,
    input wire [1:0] node_below_fraction_in,
    input wire [1:0] current_zero_in,
    input wire [1:0] overcurrent_guard_in,
    input wire thermal_fault_in,
    input wire pump_rail_low_in,
    input wire gate_rail_low_in,
    input wire supply_lockout_in,
    output reg origin_flag_n_out,
    output reg [4:0] step_index_out,
    output reg [9:0] level_a_out,
    output reg [9:0] level_b_out,
    output reg [1:0] polarity_neg_out,
    output reg [3:0] decay_mode_out,
    output reg [1:0] source_on_out,
    output reg [1:0] sink_on_out,
    output reg [1:0] sync_rect_out,
    output reg [1:0] comp_blank_out,
    output reg outputs_active_out,
    output reg overcurrent_latched_out
);
    localparam S_ON = 3'b001;
    localparam S_OFF = 3'b010;
    localparam S_IDLE = 3'b100;

    reg [4:0] idx_q;
    reg adv_q;
    reg lp_q;
    reg [9:0] lvl_a_q;
    reg [9:0] lvl_b_q;
    reg [22:0] oc_latch_q;
    reg [15:0] oc_blank_q;
    wire [9:0] rom_a;
    wire [9:0] rom_b;
    reg [4:0] step_amt;
    wire adv_edge;
    wire force_home;
    wire drive_ok;
    wire [4:0] idx_d;
    wire [4:0] idx_b;
    wire [4:0] idx_p8;

    assign adv_edge = advance_in & ~adv_q;
    // Lockout, clear, or wake edge pull the translator home
    assign force_home = ~translator_clear_n_in | supply_lockout_in |
                        (low_power_n_in & ~lp_q);
    // Enable only gates the outputs, never the translator
    assign drive_ok = translator_clear_n_in & ~outputs_on_n_in &
                      low_power_n_in & ~thermal_fault_in &
                      ~pump_rail_low_in & ~gate_rail_low_in &
                      ~supply_lockout_in & ~overcurrent_latched_out;

    // Step size from select bits, high bit first
    always @* begin
        case ({resolution_sel_hi_in, resolution_sel_lo_in})
            2'b00: step_amt = 5'h08;
            2'b01: step_amt = 5'h04;
            2'b10: step_amt = 5'h02;
            default: step_amt = 5'h01;
        endcase
    end

    // Select bits only matter at the edge direction sets sense
    assign idx_d = direction_in ? idx_q + step_amt : idx_q - step_amt;

    // Phase B lags phase A by a quarter revolution (sine vs cosine)
    assign idx_b = idx_q - 5'h08;
    // Cosine is negative from a quarter to three quarters of a turn
    assign idx_p8 = idx_q + 5'h08;

    // Fold index to quadrant offset: 0..8 eighth steps from the axis
    function [3:0] fold;
        input [4:0] i;
        begin
            fold = i[3] ? {1'b0, 3'h0} + (4'h8 - {1'b0, i[2:0]}) :
                          {1'b0, i[2:0]};
        end
    endfunction

    function [9:0] mag;
        input [3:0] f;
        input [9:0] r;
        begin
            mag = (f == 4'h8) ? 10'h000 : r;
        end
    endfunction

    wire [3:0] fa;
    wire [3:0] fb;
    assign fa = fold(idx_q);
    assign fb = fold(idx_b);

    // Magnitudes are the table percentage of full scale
    mst_sine_rom u_rom_a (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .addr_in(fa[2:0]),
        .data_out(rom_a)
    );
    mst_sine_rom u_rom_b (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .addr_in(fb[2:0]),
        .data_out(rom_b)
    );

    // Index update: home on reset, clear, lockout or wake edge, else step on edges
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            idx_q <= `MST_HOME_IDX;
            adv_q <= 1'b0;
            lp_q <= 1'b1;
        end else begin
            adv_q <= advance_in;
            lp_q <= low_power_n_in;
            if (force_home) begin
                idx_q <= `MST_HOME_IDX;
            end else if (adv_edge) begin
                idx_q <= idx_d;
            end
        end
    end

    // Level pipeline: table data lag the index by one register stage,
    // so the fold offset is delayed to stay paired with the ROM word
    reg lvl_upd_q;
    reg lvl_cmp_q;
    reg [1:0] dec_a_q;
    reg [1:0] dec_b_q;
    reg [3:0] fa_q;
    reg [3:0] fb_q;
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lvl_upd_q <= 1'b0;
            lvl_cmp_q <= 1'b0;
            fa_q <= 4'h0;
            fb_q <= 4'h0;
            lvl_a_q <= 10'h000;
            lvl_b_q <= 10'h000;
            dec_a_q <= `MST_DECAY_MIXED;
            dec_b_q <= `MST_DECAY_MIXED;
        end else begin
            lvl_upd_q <= adv_edge & ~force_home;
            lvl_cmp_q <= lvl_upd_q & ~force_home;
            fa_q <= fa;
            fb_q <= fb;
            // Home reload gets mixed decay, a step compares levels
            if (force_home) begin
                dec_a_q <= `MST_DECAY_MIXED;
                dec_b_q <= `MST_DECAY_MIXED;
            end else if (lvl_cmp_q) begin
                dec_a_q <= (mag(fa_q, rom_a) >= lvl_a_q) ? `MST_DECAY_SLOW
                           : fast_decay_fraction_in;
                dec_b_q <= (mag(fb_q, rom_b) >= lvl_b_q) ? `MST_DECAY_SLOW
                           : fast_decay_fraction_in;
            end
            // Levels follow the table continuously, home included
            lvl_a_q <= mag(fa_q, rom_a);
            lvl_b_q <= mag(fb_q, rom_b);
        end
    end

    // Overcurrent: qualify past blank time, then hold off
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            oc_blank_q <= 16'h0000;
            oc_latch_q <= 23'h000000;
            overcurrent_latched_out <= 1'b0;
        end else begin
            if (|overcurrent_guard_in) begin
                oc_blank_q <= oc_blank_q + 16'h0001;
            end else begin
                oc_blank_q <= 16'h0000;
            end
            if (oc_latch_q != 23'h000000) begin
                oc_latch_q <= oc_latch_q - 23'h000001;
                overcurrent_latched_out <= (oc_latch_q != 23'h000001);
            end else if (oc_blank_q >= OC_BLANK_CYC[15:0]) begin
                oc_latch_q <= OC_LATCH_CYC[22:0];
                overcurrent_latched_out <= 1'b1;
                oc_blank_q <= 16'h0000;
            end
        end
    end

    // Per-bridge chopper: on, trip, off one-shot, re-enable with blank
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_br
            reg [2:0] st_q;
            reg [15:0] off_q;
            reg [15:0] blk_q;
            reg fast_ph_q;
            wire [1:0] dm;
            assign dm = (g == 0) ? dec_a_q : dec_b_q;
            always @(posedge clk_sys_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    st_q <= S_IDLE;
                    off_q <= 16'h0000;
                    blk_q <= 16'h0000;
                    fast_ph_q <= 1'b0;
                end else if (!drive_ok) begin
                    st_q <= S_IDLE;
                    fast_ph_q <= 1'b0;
                end else begin
                    if (blk_q != 16'h0000) begin
                        blk_q <= blk_q - 16'h0001;
                    end
                    case (st_q)
                        S_IDLE: begin
                            st_q <= S_ON;
                            blk_q <= BLANK_CYC[15:0];
                        end
                        S_ON: begin
                            // Trip only seen after blanking
                            if (trip_in[g] && blk_q == 16'h0000) begin
                                st_q <= S_OFF;
                                off_q <= OFF_CYC[15:0];
                                blk_q <= BLANK_CYC[15:0];
                                fast_ph_q <= (dm != `MST_DECAY_SLOW);
                            end
                        end
                        S_OFF: begin
                            // Mixed ends fast part at node threshold
                            if (dm == `MST_DECAY_MIXED &&
                                node_below_fraction_in[g]) begin
                                fast_ph_q <= 1'b0;
                            end
                            if (off_q == 16'h0001) begin
                                st_q <= S_ON;
                                blk_q <= BLANK_CYC[15:0];
                                fast_ph_q <= 1'b0;
                            end
                            off_q <= off_q - 16'h0001;
                        end
                        default: st_q <= S_IDLE;
                    endcase
                end
            end

            // Slow decay drops the source only; fast drops both
            always @(posedge clk_sys_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    source_on_out[g] <= 1'b0;
                    sink_on_out[g] <= 1'b0;
                    sync_rect_out[g] <= 1'b0;
                    comp_blank_out[g] <= 1'b1;
                end else begin
                    source_on_out[g] <= drive_ok & (st_q == S_ON);
                    sink_on_out[g] <= drive_ok & ((st_q == S_ON) |
                        ((st_q == S_OFF) & ~fast_ph_q));
                    // Stop at zero current to avoid reversal
                    sync_rect_out[g] <= drive_ok & (st_q == S_OFF) &
                        ~rectifier_disable_in & ~current_zero_in[g];
                    comp_blank_out[g] <= (blk_q != 16'h0000);
                end
            end
        end
    endgenerate

    // Registered status and levels
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            origin_flag_n_out <= 1'b0;
            step_index_out <= `MST_HOME_IDX;
            level_a_out <= 10'h000;
            level_b_out <= 10'h000;
            polarity_neg_out <= 2'h0;
            decay_mode_out <= {`MST_DECAY_MIXED, `MST_DECAY_MIXED};
            outputs_active_out <= 1'b0;
        end else begin
            origin_flag_n_out <= (idx_q != `MST_HOME_IDX);
            step_index_out <= idx_q;
            level_a_out <= lvl_a_q;
            level_b_out <= lvl_b_q;
            polarity_neg_out <= {idx_q[4], idx_p8[4]};
            decay_mode_out <= {dec_b_q, dec_a_q};
            outputs_active_out <= drive_ok;
        end
    end
endmodule

// [hw/mst_regs.vh]
`ifndef MST_REGS_VH
`define MST_REGS_VH
// How it works
// - Select bits 00 full to 11 eighth
// - Reset loads home index, mixed decay
// - Advance edge steps index, sets currents, polarities
// - Select bits sampled only at advance edge
// - Direction level picks forward or backward
// - Level not lower selects slow decay
// - Lower level takes fraction-selected decay
// - Fraction input is three-valued setting
// - Trip resets latch; decay picks drivers off
// - Off one-shot holds drivers off, restarts
// - Blank comparator on entering on or off state, not at mixed fast-to-slow switch
// - Mixed: fast until node threshold, then slow
// - Trip level is table percentage of full-scale
// - Translator clear forces home, outputs off
// - Origin flag low only at home index
// - Rectifier on in decay unless disabled, zero-stop
// - Outputs-on high disables outputs only
// - Low power disables; rising edge homes translator
// - Thermal or rail faults disable outputs
// - Supply lockout disables drivers, homes translator
// - Overcurrent past blank latches off 1.6 ms
// - Home index is 45 degree step
// - 32 eighth steps per revolution, cosine table

`define MST_CLK_HZ 20000000
`define MST_HOME_IDX 5'h04
`define MST_IDX_W 5
`define MST_DECAY_SLOW 2'h0
`define MST_DECAY_FAST 2'h1
`define MST_DECAY_MIXED 2'h2
`define MST_OC_LATCH_US 1600
`define MST_OC_BLANK_NS 1500
`define MST_OC_LATCH_CYC ((`MST_OC_LATCH_US * 20) )
`define MST_OC_BLANK_CYC ((`MST_OC_BLANK_NS * 20 + 999) / 1000)
`endif

// [hw/mst_sine_rom.v]
// Registered table of phase magnitudes in tenths of a percent
module mst_sine_rom (
    input wire clk_sys_in,
    input wire nrst_in,
    input wire [2:0] addr_in,
    output reg [9:0] data_out
);
    // Magnitude for angle offsets 0..7 eighth steps within a quadrant
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            data_out <= 10'h000;
        end else begin
            case (addr_in)
                3'h0: data_out <= 10'h3E8; // 100.0
                3'h1: data_out <= 10'h3D5; // 98.1
                3'h2: data_out <= 10'h39C; // 92.4
                3'h3: data_out <= 10'h33F; // 83.1
                3'h4: data_out <= 10'h2C3; // 70.7
                3'h5: data_out <= 10'h22C; // 55.6
                3'h6: data_out <= 10'h17F; // 38.3
                3'h7: data_out <= 10'h0C3; // 19.5
                default: data_out <= 10'h000;
            endcase
        end
    end
endmodule

// [verification/mst_translator_monitor.sv]
module mst_translator_monitor (
    input wire clk_sys_in,
    input wire nrst_in,
    input wire advance_in,
    input wire direction_in,
    input wire resolution_sel_lo_in,
    input wire resolution_sel_hi_in,
    input wire translator_clear_n_in,
    input wire outputs_on_n_in,
    input wire low_power_n_in,
    input wire thermal_fault_in,
    input wire pump_rail_low_in,
    input wire gate_rail_low_in,
    input wire supply_lockout_in,
    input wire origin_flag_n_out,
    input wire [4:0] step_index_out,
    input wire [1:0] source_on_out,
    input wire outputs_active_out,
    input wire overcurrent_latched_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] stp;
    logic [4:0] nxt;
    // Expected index if the present edge is taken
    assign stp = 4'h8 >> {resolution_sel_hi_in, resolution_sel_lo_in};
    assign nxt = direction_in ? step_index_out + {1'b0, stp}
                              : step_index_out - {1'b0, stp};
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    sequence adv_edge;
        $rose(advance_in) && translator_clear_n_in && low_power_n_in &&
            !supply_lockout_in;
    endsequence
    sequence held_clear;
        (!translator_clear_n_in)[*4];
    endsequence
    a_step_size: assert property (adv_edge |-> ##2 step_index_out == $past(nxt, 2))
        else $error("index step wrong");
    a_home_flag: assert property (origin_flag_n_out == (step_index_out != 5'h04))
        else $error("origin flag wrong");
    a_clear_home: assert property (held_clear |-> step_index_out == 5'h04)
        else $error("clear did not home");
    a_clear_off: assert property (held_clear |-> !outputs_active_out && source_on_out == 2'h0)
        else $error("clear left outputs on");
    a_enable_off: assert property (outputs_on_n_in[*4] |-> !outputs_active_out)
        else $error("enable high left outputs on");
    a_fault_off: assert property ((thermal_fault_in || pump_rail_low_in || gate_rail_low_in)[*4] |-> !outputs_active_out)
        else $error("fault left outputs on");
    a_lockout_home: assert property (supply_lockout_in[*4] |-> step_index_out == 5'h04 && !outputs_active_out)
        else $error("lockout not applied");
    a_sleep_off: assert property ((!low_power_n_in)[*4] |-> !outputs_active_out)
        else $error("low power left outputs on");
    a_oc_hold: assert property ($rose(overcurrent_latched_out) |=> overcurrent_latched_out[*8])
        else $error("overcurrent latch too short");
    a_oc_off: assert property (overcurrent_latched_out[*2] |-> !outputs_active_out)
        else $error("overcurrent left outputs on");
endmodule

// [verification/mst_step_ctrl.sv]
// Controller model issuing advance pulses of fixed high and low width
module mst_step_ctrl #(
    parameter int HOLD_CYC = 20,
    parameter int WAKE_CYC = 20000
) (
    input wire clk_sys_in,
    input wire nrst_in,
    input wire low_power_n_in,
    input wire go_in,
    output logic advance_out,
    output logic busy_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] wake_q;
    logic [7:0] ph_q;
    logic lp_q;
    assign busy_out = (ph_q != 8'h00) || (wake_q != 16'h0000);
    // Drives on the falling edge so the block samples settled levels
    always @(negedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            advance_out <= 1'b0;
            ph_q <= 8'h00;
            wake_q <= 16'h0000;
            lp_q <= 1'b0;
        end else begin
            lp_q <= low_power_n_in;
            if (low_power_n_in && !lp_q)
                wake_q <= 16'(WAKE_CYC);
            else if (wake_q != 16'h0000)
                wake_q <= wake_q - 16'h0001;
            if (ph_q != 8'h00) begin
                ph_q <= ph_q - 8'h01;
                advance_out <= (ph_q - 8'h01) > 8'(HOLD_CYC);
            end else if (go_in && wake_q == 16'h0000) begin
                ph_q <= 8'(2 * HOLD_CYC);
                advance_out <= 1'b1;
            end
        end
    end
endmodule

// [verification/mst_translator_test.sv]
module mst_translator_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_in, nrst_in, go, busy, adv, dir, hi, lo, clr_n, oe_n;
    logic lp_n, th, pr, gr, lock;
    logic [1:0] frac, ocg;
    wire flag_n, act, ocl;
    wire [4:0] idx;
    wire [9:0] la, lb;
    wire [1:0] pol;
    wire [3:0] dm;
    logic [4:0] e;
    int err_total = 0;
    int n_checks = 0;
    logic [9:0] tbl [0:8] = '{10'h3E8, 10'h3D5, 10'h39C, 10'h33F, 10'h2C3,
        10'h22C, 10'h17F, 10'h0C3, 10'h000};
    mst_translator #(.OC_LATCH_CYC(50)) dut (
        .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .advance_in(adv),
        .direction_in(dir), .resolution_sel_lo_in(lo),
        .resolution_sel_hi_in(hi), .fast_decay_fraction_in(frac),
        .translator_clear_n_in(clr_n), .outputs_on_n_in(oe_n),
        .low_power_n_in(lp_n), .rectifier_disable_in(1'b0),
        .trip_in(2'h0), .node_below_fraction_in(2'h0),
        .current_zero_in(2'h0), .overcurrent_guard_in(ocg),
        .thermal_fault_in(th), .pump_rail_low_in(pr), .gate_rail_low_in(gr),
        .supply_lockout_in(lock), .origin_flag_n_out(flag_n),
        .step_index_out(idx), .level_a_out(la), .level_b_out(lb),
        .polarity_neg_out(pol), .decay_mode_out(dm), .source_on_out(),
        .sink_on_out(), .sync_rect_out(), .comp_blank_out(),
        .outputs_active_out(act), .overcurrent_latched_out(ocl));
    mst_step_ctrl ctrl (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .low_power_n_in(lp_n), .go_in(go), .advance_out(adv),
        .busy_out(busy));
    task automatic chk(input string nm, input logic [9:0] x, input logic [9:0] g);
        n_checks++;
        if (g !== x) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    function automatic logic [9:0] mag(input logic [4:0] i);
        return tbl[(i[3:0] > 4'h8) ? 5'h10 - i[3:0] : {1'b0, i[3:0]}];
    endfunction
    task automatic cycles(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    // Bounded wait; the wake delay of the controller is the longest
    task automatic wait_idle;
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 25000) begin
            @(negedge clk_sys_in);
            k++;
        end
        if (k >= 25000) begin
            err_total++;
            finish_test();
        end
    endtask
    task automatic step(input logic d, input logic h, input logic l);
        wait_idle();
        dir <= d;
        hi <= h;
        lo <= l;
        go <= 1'b1;
        @(negedge clk_sys_in) go <= 1'b0;
        @(negedge clk_sys_in);
        wait_idle();
        cycles(8);
    endtask
    // Index, flag, both levels and phase A sign for a given eighth-step index
    task automatic exp_state(input logic [4:0] i);
        chk("index", 10'(i), 10'(idx));
        chk("flag", 10'(i != 5'h04), 10'(flag_n));
        chk("level_a", mag(i), la);
        chk("level_b", mag(i - 5'h08), lb);
        if (mag(i) != 10'h000)
            chk("sign_a", 10'(i > 8 && i < 24), 10'(pol[0]));
    endtask
    initial begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        {nrst_in, go, hi, lo, frac, th, pr, gr, lock, ocg, oe_n} = '0;
        {dir, clr_n, lp_n} = 3'h7;
        cycles(12);
        nrst_in <= 1'b1;
        cycles(8);
        exp_state(5'h04);
        chk("decay", 10'(4'hA), 10'(dm));
        chk("active", 10'(1), 10'(act));
        e = 5'h04;
        for (int k = 0; k < 4; k++) begin
            step(1'b1, k[1], k[0]);
            e = e + (5'h08 >> k);
            exp_state(e);
        end
        @(negedge clk_sys_in) {hi, lo} <= 2'h0;
        cycles(10);
        chk("index", 10'(e), 10'(idx));
        for (int f = 0; f < 3; f++) begin
            @(negedge clk_sys_in) frac <= f[1:0];
            step(1'b0, 1'b1, 1'b1);
            e = e - 5'h01;
            exp_state(e);
            chk("decay", 10'({f[1:0], 2'h0}), 10'(dm));
        end
        @(negedge clk_sys_in) clr_n <= 1'b0;
        step(1'b1, 1'b1, 1'b1);
        exp_state(5'h04);
        chk("active", 10'(0), 10'(act));
        clr_n <= 1'b1;
        oe_n <= 1'b1;
        step(1'b1, 1'b1, 1'b1);
        exp_state(5'h05);
        chk("active", 10'(0), 10'(act));
        oe_n <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            {th, pr, gr} <= 3'h1 << k;
            cycles(5);
            chk("active", 10'(0), 10'(act));
            {th, pr, gr} <= 3'h0;
            cycles(5);
            chk("active", 10'(1), 10'(act));
        end
        lock <= 1'b1;
        cycles(6);
        chk("index", 10'(4), 10'(idx));
        chk("active", 10'(0), 10'(act));
        lock <= 1'b0;
        step(1'b1, 1'b0, 1'b0);
        lp_n <= 1'b0;
        cycles(5);
        chk("active", 10'(0), 10'(act));
        lp_n <= 1'b1;
        cycles(6);
        exp_state(5'h04);
        step(1'b1, 1'b1, 1'b1);
        exp_state(5'h05);
        ocg <= 2'h1;
        cycles(40);
        chk("oc_latch", 10'(1), 10'(ocl));
        chk("active", 10'(0), 10'(act));
        ocg <= 2'h0;
        cycles(20);
        chk("oc_latch", 10'(1), 10'(ocl));
        cycles(40);
        chk("oc_latch", 10'(0), 10'(ocl));
        finish_test();
    end
endmodule

bind mst_translator mst_translator_monitor mon (.*);
